// ### logic/dpd_top.sv
// protection, diagnostics and output control for five power drivers
// assumes raw analog comparator levels arrive asynchronously, APB on clk
`timescale 1ns/1ps

module dpd_top #(
  parameter int OL_FILTER_CYCLES = dpd_pkg::OL_FILTER_CYC,
  parameter int OC_OFF_12_CYCLES = dpd_pkg::OC_OFF_12_CYC,
  parameter int OC_OFF_25_CYCLES = dpd_pkg::OC_OFF_25_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // raw comparator levels, asynchronous
  input  wire logic [dpd_pkg::DRV_N-1:0]  oc_raw,
  input  wire logic [dpd_pkg::DRV_N-1:0]  ol_raw,
  input  wire logic                       tw_raw,
  input  wire logic                       tsd_raw,
  input  wire logic                       tsd_cool_raw,
  input  wire logic                       uv_raw,
  input  wire logic                       ov_raw,
  input  wire logic                       pwm_in,
  // power stage controls
  output logic      [dpd_pkg::DRV_N-1:0]  high_side_switch_on,
  output logic      [dpd_pkg::HB_N-1:0]   low_side_switch_on,
  output logic      [dpd_pkg::HB_N-1:0]   high_side_fast_off,
  output logic      [dpd_pkg::HB_N-1:0]   low_side_fast_off,
  output logic                            charge_pump_en,
  // current monitor select and summary fault
  output logic      [dpd_pkg::DRV_N-1:0]  monitor_sel,
  output logic                            fault
);
  import dpd_pkg::*;

  localparam logic [REC_W-1:0] OFF12 = REC_W'(OC_OFF_12_CYCLES - 1);
  localparam logic [REC_W-1:0] OFF25 = REC_W'(OC_OFF_25_CYCLES - 1);

  // monitor select decode, one-hot, none for codes above four
  function automatic logic [DRV_N-1:0] dpd_mon_decode(
    input logic [MON_W-1:0] sel
  );
    logic [DRV_N-1:0] hot;
    hot = '0;
    for (int k = 0; k < DRV_N; k++) begin
      if (sel == MON_W'(k)) begin
        hot[k] = 1'b1;
      end
    end
    return hot;
  endfunction : dpd_mon_decode

  logic [RAW_N-1:0]  raw_bus;
  logic [RAW_N-1:0]  sync1;
  logic [RAW_N-1:0]  sync2;
  logic [CTRL_W-1:0] ctrl0;
  logic [CTRL_W-1:0] ctrl1;
  logic [DRV_N-1:0]  oc_q;
  logic [DRV_N-1:0]  ol_q;
  logic              tw_q;
  logic              tsd_q;
  logic              uv_q;
  logic              ov_q;
  logic [DRV_N-1:0]  oc_q_d;
  logic [DRV_N-1:0]  oc_flag;
  logic [DRV_N-1:0]  ol_flag;
  logic              tw_flag;
  logic              tsd_flag;
  logic              uv_flag;
  logic              ov_flag;
  logic              tsd_hot;
  logic [REC_W-1:0]  rec_cnt [DRV_N];
  logic [DRV_N-1:0]  rec_off;
  logic [DRV_N-1:0]  drv_block;
  logic [DRV_N-1:0]  drv_active;
  logic [DRV_N-1:0]  rec_en;
  logic [DRV_N-1:0]  pwm_en;
  logic [OUT_W-1:0]  out_bits;
  logic              all_off;
  logic              wr_acc;
  logic              rd_setup;
  logic              clear_all;
  logic              addr_ok;
  logic [CTRL_W-1:0] stat0;
  logic [CTRL_W-1:0] stat1;
  logic [31:0]       next_prdata;

  // comparator levels gathered for a common two-stage synchroniser
  assign raw_bus = {pwm_in, ov_raw, uv_raw, tsd_cool_raw, tsd_raw, tw_raw,
                    ol_raw, oc_raw};

  // synchroniser, first stage read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_bus;
      sync2 <= sync1;
    end
  end

  // per-driver filters; open load counts only on an active output
  for (genvar i = 0; i < DRV_N; i++) begin : g_filt
    dpd_filter #(.CYCLES(OC_FILTER_CYC)) u_oc (
      .clk     (clk),
      .rst     (rst),
      .cond_in (sync2[RAW_OC+i]),
      .qual    (oc_q[i])
    );
    dpd_filter #(.CYCLES(OL_FILTER_CYCLES)) u_ol (
      .clk     (clk),
      .rst     (rst),
      .cond_in (sync2[RAW_OL+i] & drv_active[i]),
      .qual    (ol_q[i])
    );
  end

  dpd_filter #(.CYCLES(OC_FILTER_CYC)) u_tw (
    .clk     (clk),
    .rst     (rst),
    .cond_in (sync2[RAW_TW]),
    .qual    (tw_q)
  );
  dpd_filter #(.CYCLES(OC_FILTER_CYC)) u_tsd (
    .clk     (clk),
    .rst     (rst),
    .cond_in (sync2[RAW_TSD]),
    .qual    (tsd_q)
  );
  dpd_filter #(.CYCLES(OC_FILTER_CYC)) u_uv (
    .clk     (clk),
    .rst     (rst),
    .cond_in (sync2[RAW_UV]),
    .qual    (uv_q)
  );
  dpd_filter #(.CYCLES(OC_FILTER_CYC)) u_ov (
    .clk     (clk),
    .rst     (rst),
    .cond_in (sync2[RAW_OV]),
    .qual    (ov_q)
  );

  // apb decode; zero wait states, error on unmapped words
  assign pready   = 1'b1;
  assign addr_ok  = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) ||
                    (paddr == ADDR_STAT0) || (paddr == ADDR_STAT1);
  assign pslverr  = psel & penable & ~addr_ok;
  assign wr_acc   = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  // clear request from either control word
  assign clear_all = wr_acc & pwdata[CTRL_CLR_BIT] &
                     ((paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1));

  // control registers; the clear bit is an action, not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0 <= CTRL_RST;
      ctrl1 <= CTRL_RST;
    end else if (wr_acc && paddr == ADDR_CTRL0) begin
      ctrl0 <= {1'b0, pwdata[CTRL_W-2:0]};
    end else if (wr_acc && paddr == ADDR_CTRL1) begin
      ctrl1 <= {1'b0, pwdata[CTRL_W-2:0]};
    end
  end

  // control fields
  assign rec_en   = ctrl0[CTRL0_REC_LSB +: DRV_N];
  assign out_bits = ctrl1[CTRL1_OUT_LSB +: OUT_W];
  assign pwm_en   = ctrl1[CTRL1_PWM_LSB +: DRV_N];

  // sticky status flags; a qualifying condition wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_flag  <= '0;
      ol_flag  <= '0;
      tw_flag  <= 1'b0;
      tsd_flag <= 1'b0;
      uv_flag  <= 1'b0;
      ov_flag  <= 1'b0;
    end else begin
      oc_flag  <= oc_q | (oc_flag & {DRV_N{~clear_all}});
      ol_flag  <= ol_q | (ol_flag & {DRV_N{~clear_all}});
      tw_flag  <= tw_q | (tw_flag & ~clear_all);
      tsd_flag <= tsd_q | (tsd_flag & ~clear_all);
      uv_flag  <= uv_q | (uv_flag & ~clear_all);
      ov_flag  <= ov_q | (ov_flag & ~clear_all);
    end
  end

  // hold shutdown until die has cooled past hysteresis
  always_ff @(posedge clk) begin
    if (rst) begin
      tsd_hot <= 1'b0;
    end else if (tsd_q) begin
      tsd_hot <= 1'b1;
    end else if (sync2[RAW_COOL]) begin
      tsd_hot <= 1'b0;
    end
  end

  // trip edge detect on the qualified overcurrent level
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_q_d <= '0;
    end else begin
      oc_q_d <= oc_q;
    end
  end

  // recovery off-time counters, one per driver
  for (genvar i = 0; i < DRV_N; i++) begin : g_rec
    always_ff @(posedge clk) begin
      if (rst) begin
        rec_cnt[i] <= '0;
      end else if (oc_q[i] && !oc_q_d[i]) begin
        rec_cnt[i] <= ctrl0[CTRL0_DUTY_BIT] ? OFF25 : OFF12;
      end else if (rec_cnt[i] != '0) begin
        rec_cnt[i] <= rec_cnt[i] - 1'b1;
      end
    end
    // off from trip through off time
    assign rec_off[i]   = (oc_q[i] & ~oc_q_d[i]) | (rec_cnt[i] != '0);
    // recovery mode ignores latched flag; otherwise it blocks
    assign drv_block[i] = rec_off[i] | (oc_flag[i] & ~rec_en[i]);
  end

  // outputs floated by supply or temperature; warnings take no part
  // supply gating and its recovery
  // open-load and warning flags never reach this term
  assign all_off = tsd_flag | tsd_hot | uv_q | ov_q |
                   (ctrl0[CTRL0_UVREC_BIT] & (uv_flag | ov_flag));

  always_ff @(posedge clk) begin
    if (rst) begin
      charge_pump_en <= 1'b0;
    end else begin
      charge_pump_en <= ~ov_q;
    end
  end

  // half bridges: control bits in pairs, low side then high side
  for (genvar b = 0; b < HB_N; b++) begin : g_hb
    logic pwm_gate;
    assign pwm_gate = ~pwm_en[b] | sync2[RAW_PWM];
    dpd_bridge u_hb (
      .clk         (clk),
      .rst         (rst),
      .hs_cmd      (out_bits[2*b+1] & pwm_gate),
      .ls_cmd      (out_bits[2*b] & pwm_gate),
      .enable      (~drv_block[b] & ~all_off),
      .hs_on       (high_side_switch_on[b]),
      .ls_on       (low_side_switch_on[b]),
      .hs_fast_off (high_side_fast_off[b]),
      .ls_fast_off (low_side_fast_off[b])
    );
    assign drv_active[b] = high_side_switch_on[b] | low_side_switch_on[b];
  end

  // high-side only drivers take one control bit each; a local flop keeps
  // the gate vector free of mixed procedural and port drivers
  for (genvar h = HB_N; h < DRV_N; h++) begin : g_hs
    logic sw_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        sw_q <= 1'b0;
      end else begin
        sw_q <= out_bits[HB_N+h] & (~pwm_en[h] | sync2[RAW_PWM]) &
                ~drv_block[h] & ~all_off;
      end
    end
    assign high_side_switch_on[h] = sw_q;
    assign drv_active[h]          = sw_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_sel <= '0;
    end else begin
      monitor_sel <= dpd_mon_decode(ctrl0[CTRL0_MON_LSB +: MON_W]);
    end
  end

  // status words; bit 15 always one so a dead bus is visible
  always_comb begin
    stat0 = '0;
    stat1 = '0;
    stat0[STAT0_OC_LSB +: DRV_N] = oc_flag;
    stat0[STAT0_TW_BIT]          = tw_flag;
    stat0[STAT0_TSD_BIT]         = tsd_flag;
    stat0[STAT0_UV_BIT]          = uv_flag;
    stat0[STAT0_OV_BIT]          = ov_flag;
    stat1[STAT1_OL_LSB +: DRV_N] = ol_flag;
    stat0[STAT_FAULT_BIT]        = fault;
    stat1[STAT_FAULT_BIT]        = fault;
    stat0[STAT_ONE_BIT]          = 1'b1;
    stat1[STAT_ONE_BIT]          = 1'b1;
  end

  // summary fault is the or of every flag
  assign fault = (|oc_flag) | (|ol_flag) | tw_flag | tsd_flag |
                 uv_flag | ov_flag;

  // read mux, captured in setup so data stand in the access cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL0: next_prdata = {16'h0000, ctrl0};
      ADDR_CTRL1: next_prdata = {16'h0000, ctrl1};
      ADDR_STAT0: next_prdata = {16'h0000, stat0};
      ADDR_STAT1: next_prdata = {16'h0000, stat1};
      default:    next_prdata = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end
endmodule : dpd_top

// ### logic/dpd_pkg.sv
// constants shared by the driver protection and diagnostics block
// assumes a 100 MHz system clock and an APB register bus with 12-bit address
package dpd_pkg;
  // driver counts: three half bridges, two high-side switches
  localparam int DRV_N = 5;
  localparam int HB_N  = 3;

  // clock rate and filter / delay times in their own units
  localparam int CLK_MHZ       = 100;
  localparam int OC_FILTER_US  = 32;    // overcurrent_filter_time
  localparam int OL_FILTER_US  = 1000;  // open_load_filter_time
  localparam int XCUR_TIME_NS  = 2000;  // cross-current protection time

  // derived cycle counts (least times round up)
  localparam int OC_FILTER_CYC = OC_FILTER_US * CLK_MHZ;
  localparam int OL_FILTER_CYC = OL_FILTER_US * CLK_MHZ;
  localparam int XCUR_CYC      = (XCUR_TIME_NS * CLK_MHZ + 999) / 1000;

  // recovery off time as a multiple of the filter time: 1/8 or 1/4 duty
  localparam int OFF_MULT_12   = 7;
  localparam int OFF_MULT_25   = 3;
  localparam int OC_OFF_12_CYC = OC_FILTER_CYC * OFF_MULT_12;
  localparam int OC_OFF_25_CYC = OC_FILTER_CYC * OFF_MULT_25;
  localparam int REC_W         = 16;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL0 = 12'h000;
  localparam logic [11:0] ADDR_CTRL1 = 12'h004;
  localparam logic [11:0] ADDR_STAT0 = 12'h008;
  localparam logic [11:0] ADDR_STAT1 = 12'h00c;

  // control register fields
  localparam int CTRL_W          = 16;
  localparam int CTRL_CLR_BIT    = 15;
  localparam int CTRL0_REC_LSB   = 1;
  localparam int CTRL0_DUTY_BIT  = 6;
  localparam int CTRL0_MON_LSB   = 9;
  localparam int MON_W           = 3;
  localparam int CTRL0_UVREC_BIT = 12;
  localparam int CTRL1_OUT_LSB   = 1;
  localparam int OUT_W           = 8;
  localparam int CTRL1_PWM_LSB   = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

  // status register fields
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_ONE_BIT   = 15;
  localparam int STAT0_OC_LSB   = 1;
  localparam int STAT0_TW_BIT   = 6;
  localparam int STAT0_TSD_BIT  = 7;
  localparam int STAT0_UV_BIT   = 8;
  localparam int STAT0_OV_BIT   = 9;
  localparam int STAT1_OL_LSB   = 1;

  // raw condition vector layout (synchronised as one bus)
  localparam int RAW_OC   = 0;
  localparam int RAW_OL   = 5;
  localparam int RAW_TW   = 10;
  localparam int RAW_TSD  = 11;
  localparam int RAW_COOL = 12;
  localparam int RAW_UV   = 13;
  localparam int RAW_OV   = 14;
  localparam int RAW_PWM  = 15;
  localparam int RAW_N    = 16;
endpackage : dpd_pkg

// ### logic/dpd_filter.sv
// persistence filter: qualifies a synchronised condition after a hold time
// assumes cond_in is already in the clk domain
`timescale 1ns/1ps
module dpd_filter #(
  parameter int CYCLES = 3200
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // condition and qualified level
  input  wire logic cond_in,
  output logic      qual
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  logic [W-1:0] cnt;

  // count while present, saturate at the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (!cond_in) begin
      cnt <= '0;
    end else if (cnt != LIMIT) begin
      cnt <= cnt + 1'b1;
    end
  end

  // a glitch shorter than the hold time never reaches the flag
  assign qual = (cnt == LIMIT);
endmodule : dpd_filter

// ### logic/dpd_bridge.sv
// one half bridge: break-before-make sequencing of the two switches
// assumes commands come from logic on the same clock
`timescale 1ns/1ps
module dpd_bridge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // commands
  input  wire logic hs_cmd,
  input  wire logic ls_cmd,
  input  wire logic enable,
  // switch controls
  output logic      hs_on,
  output logic      ls_on,
  output logic      hs_fast_off,
  output logic      ls_fast_off
);
  import dpd_pkg::*;

  typedef enum logic [3:0] {
    DPD_OFF  = 4'b0001,
    DPD_HS   = 4'b0010,
    DPD_LS   = 4'b0100,
    DPD_DEAD = 4'b1000
  } dpd_hb_state_t;

  localparam logic [7:0] DEAD_LAST = 8'(XCUR_CYC - 1);

  dpd_hb_state_t state;
  logic [7:0]    dead_cnt;
  logic          last_hs;
  logic          want_hs;
  logic          want_ls;

  // both commands at once would short the supply: treat as off
  assign want_hs = enable & hs_cmd & ~ls_cmd;
  assign want_ls = enable & ls_cmd & ~hs_cmd;

  // sequencing state and dead-time counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= DPD_OFF;
      dead_cnt <= 8'h00;
      last_hs  <= 1'b0;
    end else begin
      unique case (state)
        DPD_OFF: begin
          if (want_hs) begin
            state <= DPD_HS;
          end else if (want_ls) begin
            state <= DPD_LS;
          end
        end
        DPD_HS: begin
          if (!want_hs) begin
            state    <= DPD_DEAD;
            dead_cnt <= DEAD_LAST;
            last_hs  <= 1'b1;
          end
        end
        DPD_LS: begin
          if (!want_ls) begin
            state    <= DPD_DEAD;
            dead_cnt <= DEAD_LAST;
            last_hs  <= 1'b0;
          end
        end
        DPD_DEAD: begin
          if (dead_cnt == 8'h00) begin
            state <= DPD_OFF;
          end else begin
            dead_cnt <= dead_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // gates follow state; opposite side only after the delay
  assign hs_on = (state == DPD_HS);
  assign ls_on = (state == DPD_LS);
  assign hs_fast_off = !hs_on && !(state == DPD_DEAD && last_hs);
  assign ls_fast_off = !ls_on && !(state == DPD_DEAD && !last_hs);
endmodule : dpd_bridge

// ### test/dpd_monitor.sv
// checker of the protection block's pin behaviour
// assumes binding into dpd_top with its open-load filter length
`timescale 1ns/1ps
module dpd_monitor
  import dpd_pkg::*;
#(
  parameter int OL_FILTER_CYCLES = 50
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // raw levels
  input wire logic [4:0]  oc_raw,
  input wire logic [4:0]  ol_raw,
  input wire logic        tw_raw,
  input wire logic        tsd_raw,
  input wire logic        uv_raw,
  input wire logic        ov_raw,
  // stage and status
  input wire logic [4:0]  high_side_switch_on,
  input wire logic [2:0]  low_side_switch_on,
  input wire logic [2:0]  low_side_fast_off,
  input wire logic        charge_pump_en,
  input wire logic [4:0]  monitor_sel,
  input wire logic        fault
);
  int anyn, oln, ocn, shn, ovn, lsoff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // run lengths of raw levels; lsoff starts high so reset is no switch
  always_ff @(posedge clk) begin
    if (rst) begin
      anyn  <= 0;
      oln   <= 0;
      ocn   <= 0;
      shn   <= 0;
      ovn   <= 0;
      lsoff <= 1000;
    end else begin
      anyn  <= |{oc_raw, tw_raw, tsd_raw, uv_raw, ov_raw} ? anyn + 1 : 0;
      oln   <= |(ol_raw & (high_side_switch_on | 5'(low_side_switch_on)))
               ? oln + 1 : 0;
      ocn   <= oc_raw[3] ? ocn + 1 : 0;
      shn   <= (tsd_raw | uv_raw | ov_raw) ? shn + 1 : 0;
      ovn   <= ov_raw ? ovn + 1 : 0;
      lsoff <= low_side_switch_on[0] ? 0 : lsoff + 1;
    end
  end

  // sync lag of two cycles allowed for
  property p_filt;
    $rose(fault) |-> $past(anyn, 2) >= OC_FILTER_CYC - 2
      || $past(oln, 2) >= OL_FILTER_CYCLES - 2;
  endproperty
  a_filt: assert property (p_filt) else $error("fault too early");
  property p_clr;
    $fell(fault) |-> $past(psel && penable && pwrite && pwdata[15]);
  endproperty
  a_clr: assert property (p_clr) else $error("fault fell alone");
  property p_oc;
    ocn == OC_FILTER_CYC + 6 |-> !high_side_switch_on[3];
  endproperty
  a_oc: assert property (p_oc) else $error("tripped driver on");
  property p_shut;
    shn > OC_FILTER_CYC + 6 |->
      !(|{low_side_switch_on, high_side_switch_on});
  endproperty
  a_shut: assert property (p_shut) else $error("stage on");
  property p_cp;
    ovn > OC_FILTER_CYC + 6 |-> !charge_pump_en;
  endproperty
  a_cp: assert property (p_cp) else $error("charge pump on");
  property p_mon;
    psel && penable && pwrite && paddr == ADDR_CTRL0 |-> ##2
      monitor_sel == ($past(pwdata[11:9], 2) < 3'h5
      ? 5'h01 << $past(pwdata[11:9], 2) : 5'h00);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor select");
  property p_dead;
    $rose(high_side_switch_on[0]) |-> lsoff >= XCUR_CYC;
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time");
  property p_slew;
    $fell(low_side_switch_on[0]) |-> !low_side_fast_off[0];
  endproperty
  a_slew: assert property (p_slew) else $error("fast off early");
  property p_fast;
    high_side_switch_on[0] |-> low_side_fast_off[0];
  endproperty
  a_fast: assert property (p_fast) else $error("slow off late");

  // main scenarios reached
  c_trip: cover property ($rose(fault));
  c_dead: cover property ($rose(high_side_switch_on[0]) && lsoff < 900);
  c_cp: cover property ($fell(charge_pump_en));
endmodule : dpd_monitor

// ### test/dpd_host.sv
// microcontroller model: apb master for register transfers
// assumes a block answering with pready; bench calls xfer
`timescale 1ns/1ps
module dpd_host (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // one setup cycle, request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [15:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : dpd_host

// ### test/test_driver_protection_diagnostics.sv
// self-checking bench for the driver protection block
// assumes dpd_host speaks apb; the bench drives the analog levels
`timescale 1ns/1ps
module test_driver_protection_diagnostics;
  import dpd_pkg::*;
  // clock, reset and apb
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // levels driven by the bench
  logic [4:0]  oc_raw, ol_raw, force_oc, short;
  logic        tw_raw, tsd_raw, tsd_cool_raw, uv_raw, ov_raw, pwm_in;
  // stage outputs
  logic [4:0]  high_side_switch_on, monitor_sel;
  logic [2:0]  low_side_switch_on, high_side_fast_off, low_side_fast_off;
  logic        charge_pump_en, fault;
  wire  [4:0]  hs = high_side_switch_on;
  wire  [7:0]  g = {low_side_switch_on, high_side_switch_on};
  int          n_errors, checked, cyc;

  always #5 clk = ~clk;
  dpd_host host (.*);
  dpd_top #(.OL_FILTER_CYCLES(50), .OC_OFF_12_CYCLES(70),
            .OC_OFF_25_CYCLES(30)) dut (.*);

  // idle levels; a shorted load only shows current while gated on
  initial {oc_raw, ol_raw, force_oc, short, tw_raw, tsd_raw,
           tsd_cool_raw, uv_raw, ov_raw, pwm_in} = '0;
  always @(posedge clk) oc_raw <= force_oc | (short & hs);

  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 16'h0000, r, e);
    chk("prdata", r, x);
    chk("pslverr", e, xe);
  endtask : rd

  // let dropped levels clear the sync stages first
  task automatic clr();
    wt(5);
    wr(ADDR_CTRL1, 16'h8184);
  endtask : clr

  task automatic wait_hs(input logic v);
    int n;
    n = 0;
    while (hs[3] !== v && n < 3400) begin
      @(posedge clk);
      n++;
    end
    chk("wait_hs", hs[3], v);
  endtask : wait_hs

  task automatic t_regs();
    wr(ADDR_CTRL0, 16'h9e7e);
    rd(ADDR_CTRL0, 32'h00001e7e, 1'b0);
    rd(12'h010, 32'h00000000, 1'b1);
    rd(ADDR_STAT0, 32'h00008000, 1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL0, 16'(s << 9));
      wt(3);
      chk("monitor_sel", monitor_sel, s < 5 ? 1 << s : 0);
    end
  endtask : t_regs

  task automatic t_bridge();
    wr(ADDR_CTRL1, 16'h0182);
    wt(300);
    chk("ls_on", low_side_switch_on[0], 1'b1);
    wr(ADDR_CTRL1, 16'h0184);
    wt(3);
    chk("slew", {g[5], low_side_fast_off[0], hs[0]}, 3'b000);
    chk("hs_idle", high_side_fast_off[0], 1'b1);
    wt(150);
    chk("dead", hs[0], 1'b0);
    wt(100);
    chk("hs_on", {hs, low_side_fast_off[0]}, 6'b110011);
    chk("hs_slew", high_side_fast_off[0], 1'b0);
  endtask : t_bridge

  task automatic t_pwm();
    wr(ADDR_CTRL1, 16'h1184);
    wt(6);
    chk("pwm_low", hs, 5'b10001);
    pwm_in <= 1'b1;
    wt(6);
    chk("pwm_high", hs, 5'b11001);
    pwm_in <= 1'b0;
    wr(ADDR_CTRL1, 16'h0184);
    wt(4);
  endtask : t_pwm

  // held overcurrent with one dropout, trip, host release
  task automatic t_oc();
    force_oc[3] <= 1'b1;
    wt(3000);
    force_oc[3] <= 1'b0;
    wt(1);
    force_oc[3] <= 1'b1;
    wt(3100);
    chk("early", fault, 1'b0);
    wt(120);
    chk("trip", {fault, hs}, 6'b110001);
    rd(ADDR_STAT0, 32'h00008011, 1'b0);
    force_oc[3] <= 1'b0;
    wt(100);
    chk("held_off", hs, 5'b10001);
    clr();
    wt(4);
    chk("released", {fault, hs}, 6'b011001);
  endtask : t_oc

  // self recovery at both duties, then recovery dropped
  task automatic t_rec();
    int n;
    int off;
    for (int d = 0; d < 2; d++) begin
      off = d ? 30 : 70;
      wr(ADDR_CTRL0, d ? 16'h0050 : 16'h0010);
      short[3] <= 1'b1;
      wait_hs(1'b0);
      n = 0;
      while (hs[3] !== 1'b1 && n < 300) begin
        @(posedge clk);
        n++;
      end
      chk("off_time", n >= off - 1 && n <= off + 4, 1'b1);
      short[3] <= 1'b0;
      clr();
      wt(4);
    end
    wr(ADDR_CTRL0, 16'h0000);
    short[3] <= 1'b1;
    wait_hs(1'b0);
    wt(200);
    chk("stay_off", hs[3], 1'b0);
    short[3] <= 1'b0;
    clr();
    wt(4);
    chk("back_on", hs, 5'b11001);
  endtask : t_rec

  task automatic t_diag();
    ol_raw[3] <= 1'b1;
    wt(60);
    ol_raw[3] <= 1'b0;
    chk("ol_gates", g, 8'h19);
    rd(ADDR_STAT1, 32'h00008011, 1'b0);
    clr();
    tw_raw <= 1'b1;
    wt(3220);
    chk("tw_gates", g, 8'h19);
    rd(ADDR_STAT0, 32'h00008041, 1'b0);
    tw_raw <= 1'b0;
    clr();
  endtask : t_diag

  // shutdown, uv, ov, then uv with recovery disabled
  task automatic t_supply();
    for (int k = 0; k < 4; k++) begin
      if (k == 3)
        wr(ADDR_CTRL0, 16'h1000);
      {ov_raw, uv_raw, tsd_raw} <= k == 3 ? 3'b010 : 3'b001 << k;
      wt(3220);
      chk("off", {charge_pump_en, g}, {k != 2, 8'h00});
      {ov_raw, uv_raw, tsd_raw} <= 3'b000;
      wt(300);
      chk("hold", g, k == 1 || k == 2 ? 8'h19 : 8'h00);
      tsd_cool_raw <= 1'b1;
      clr();
      wt(300);
      chk("back", {charge_pump_en, g}, 9'h119);
      tsd_cool_raw <= 1'b0;
    end
    wr(ADDR_CTRL0, 16'h0000);
  endtask : t_supply

  initial begin
    wt(8);
    rst <= 1'b0;
    t_regs();
    t_bridge();
    t_pwm();
    t_oc();
    t_rec();
    t_diag();
    t_supply();
    wrap_up();
  end
endmodule : test_driver_protection_diagnostics

bind dpd_top dpd_monitor #(.OL_FILTER_CYCLES(OL_FILTER_CYCLES)) chk_i (.*);
